// ===== hw/dphy_timing_pkg.sv
// Purpose: Shared constants and types for the D-PHY timing override bank
// Assumes: APB with 32-bit data, register index times four is the byte address
// Notes:   Timing slots follow register order, clock lane first
package dphy_timing_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Geometry
    localparam int         NUM_TIMINGS = 9;
    localparam int         VALUE_W     = 7;
    localparam int         REG_W       = 8;
    localparam int         OVR_BIT     = 7;
    localparam int         VAL_MSB     = 6;
    localparam int         DATA_W      = 32;
    localparam int         ADDR_W      = 12;
    localparam int         IDX_W       = 8;
    localparam int         IDX_LSB     = 2;

    ////////////////////////////////////////////////////////////////////////////
    // Register indices, byte address is index shifted left by IDX_LSB
    localparam logic [7:0] IDX_CLK_PREPARE  = 8'h40;
    localparam logic [7:0] IDX_CLK_ZERO     = 8'h41;
    localparam logic [7:0] IDX_CLK_TRAIL    = 8'h42;
    localparam logic [7:0] IDX_CLK_POST     = 8'h43;
    localparam logic [7:0] IDX_DATA_PREPARE = 8'h44;
    localparam logic [7:0] IDX_DATA_ZERO    = 8'h45;
    localparam logic [7:0] IDX_DATA_TRAIL   = 8'h46;
    localparam logic [7:0] IDX_DATA_EXIT    = 8'h47;
    localparam logic [7:0] IDX_LPX          = 8'h48;
    localparam logic [7:0] IDX_SUMMARY      = 8'h50;
    localparam logic [7:0] IDX_FIRST        = IDX_CLK_PREPARE;
    localparam logic [1:0] ALIGN_ZERO       = 2'h0;

    ////////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic               OVR_RESET   = 1'b0;
    localparam logic [VALUE_W-1:0] VALUE_RESET = 7'h00;

    ////////////////////////////////////////////////////////////////////////////
    // Bus slave states
    typedef enum logic [1:0] {
        APB_IDLE = 2'b01,
        APB_DONE = 2'b10
    } apb_state_t;

endpackage

// ===== hw/timing_addr_decode.sv
// Purpose: Decode an APB byte address into one timing slot or the summary word
// Assumes: Word-aligned accesses only; anything else is unmapped
// Notes:   Purely combinational
`timescale 1ns/1ps
module timing_addr_decode
    import dphy_timing_pkg::*;
(
    // Address in
    input  wire logic [ADDR_W-1:0]      paddr_i,
    // Decode out
    output logic      [NUM_TIMINGS-1:0] slot_hit_o,
    output logic                        summary_hit_o,
    output logic                        mapped_o
);

    logic [IDX_W-1:0] index;
    logic             aligned;
    logic [IDX_W-1:0] offset;

    always_comb begin
        index         = paddr_i[IDX_LSB+IDX_W-1:IDX_LSB];
        aligned       = (paddr_i[IDX_LSB-1:0] == ALIGN_ZERO) && (paddr_i[ADDR_W-1:IDX_LSB+IDX_W] == '0);
        offset        = index - IDX_FIRST;
        slot_hit_o    = '0;
        summary_hit_o = aligned && (index == IDX_SUMMARY);
        for (int i = 0; i < NUM_TIMINGS; i++) begin
            slot_hit_o[i] = aligned && (index >= IDX_FIRST) && (offset == IDX_W'(i));
        end
        mapped_o      = summary_hit_o || (slot_hit_o != '0);
    end

endmodule

// ===== hw/timing_field.sv
// Purpose: One timing register: override flag, stored value, effective value
// Assumes: Automatic value comes from logic on the same clock
// Notes:   Effective value lags the automatic input by one cycle
`timescale 1ns/1ps
module timing_field
    import dphy_timing_pkg::*;
#(
    parameter logic OVR_RST = OVR_RESET
)(
    // Clock and reset
    input  wire logic               clk_i,
    input  wire logic               rst_i,
    // Automatic timing source
    input  wire logic [VALUE_W-1:0] auto_value_i,
    // Register write
    input  wire logic               wr_i,
    input  wire logic [REG_W-1:0]   wdata_i,
    // State out
    output logic                    override_o,
    output logic      [VALUE_W-1:0] value_o,
    output logic      [REG_W-1:0]   readback_o
);

    typedef struct packed {
        logic               ovr;
        logic [VALUE_W-1:0] stored;
        logic [VALUE_W-1:0] eff;
    } field_state_t;

    field_state_t state_reg;
    field_state_t state_next;

    always_comb begin
        state_next = state_reg;
        if (wr_i) begin
            state_next.ovr = wdata_i[OVR_BIT];
            // Value lands only under override, judged by the bit being written
            if (wdata_i[OVR_BIT]) begin
                state_next.stored = wdata_i[VAL_MSB:0];
            end
        end
        // Hardware value unless software has taken over
        state_next.eff = state_next.ovr ? state_next.stored : auto_value_i;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg.ovr    <= OVR_RST;
            state_reg.stored <= VALUE_RESET;
            state_reg.eff    <= VALUE_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    assign override_o = state_reg.ovr;
    assign value_o    = state_reg.eff;
    assign readback_o = {state_reg.ovr, state_reg.eff};

endmodule

// ===== hw/csi_port0_dphy_timing_override.sv
// Purpose: D-PHY timing override bank for CSI-2 output port zero, on APB
// Assumes: Automatic timing values arrive from the lane timing engine, same clock
// Notes:   One wait state on every transfer; unmapped access answers pslverr
//
// Behaviour
// - Register 0x40 bit 7 clear gives automatic clock prepare time, set gives bits 6:0.
// - Register 0x41 bit 7 clear gives automatic clock zero time, set gives bits 6:0.
// - Register 0x42 bit 7 clear gives automatic clock trail time, set gives bits 6:0.
// - Register 0x43 bit 7 clear gives automatic clock post time, set gives bits 6:0.
// - Register 0x44 bit 7 clear gives automatic data prepare time, set gives bits 6:0.
// - Register 0x45 bit 7 clear gives automatic data zero time, set gives bits 6:0.
// - Register 0x46 bit 7 clear gives automatic data trail time, set gives bits 6:0.
// - Register 0x47 bit 7 clear gives automatic data exit time, set gives bits 6:0.
// - Without override the value field ignores writes and reads the computed value.
// - With override the value field is writable and reads back what was stored.
// - Zero, trail, post and exit override bits of both lanes come out of reset clear.
// - Register 0x48 bit 7 clear gives automatic LPX time, set gives bits 6:0.
`timescale 1ns/1ps
module csi_port0_dphy_timing_override
    import dphy_timing_pkg::*;
#(
    parameter logic CLK_PREPARE_OVR_RST  = OVR_RESET,
    parameter logic DATA_PREPARE_OVR_RST = OVR_RESET,
    parameter logic LPX_OVR_RST          = OVR_RESET
)(
    // Clock and reset
    input  wire logic               clk_i,
    input  wire logic               rst_i,
    // APB slave
    input  wire logic               psel_i,
    input  wire logic               penable_i,
    input  wire logic               pwrite_i,
    input  wire logic [ADDR_W-1:0]  paddr_i,
    input  wire logic [DATA_W-1:0]  pwdata_i,
    input  wire logic [3:0]         pstrb_i,
    output logic                    pready_o,
    output logic      [DATA_W-1:0]  prdata_o,
    output logic                    pslverr_o,
    // Automatically determined timing values
    input  wire logic [VALUE_W-1:0] clk_prepare_auto_i,
    input  wire logic [VALUE_W-1:0] clk_zero_auto_i,
    input  wire logic [VALUE_W-1:0] clk_trail_auto_i,
    input  wire logic [VALUE_W-1:0] clk_post_auto_i,
    input  wire logic [VALUE_W-1:0] data_prepare_auto_i,
    input  wire logic [VALUE_W-1:0] data_zero_auto_i,
    input  wire logic [VALUE_W-1:0] data_trail_auto_i,
    input  wire logic [VALUE_W-1:0] data_exit_auto_i,
    input  wire logic [VALUE_W-1:0] lpx_auto_i,
    // Effective timing values to the lane sequencer
    output logic      [VALUE_W-1:0] clk_prepare_value_o,
    output logic      [VALUE_W-1:0] clk_zero_value_o,
    output logic      [VALUE_W-1:0] clk_trail_value_o,
    output logic      [VALUE_W-1:0] clk_post_value_o,
    output logic      [VALUE_W-1:0] data_prepare_value_o,
    output logic      [VALUE_W-1:0] data_zero_value_o,
    output logic      [VALUE_W-1:0] data_trail_value_o,
    output logic      [VALUE_W-1:0] data_exit_value_o,
    output logic      [VALUE_W-1:0] lpx_value_o,
    // Override flags
    output logic                    clk_prepare_override_en_o,
    output logic                    clk_zero_override_en_o,
    output logic                    clk_trail_override_en_o,
    output logic                    clk_post_override_en_o,
    output logic                    data_prepare_override_en_o,
    output logic                    data_zero_override_en_o,
    output logic                    data_trail_override_en_o,
    output logic                    data_exit_override_en_o,
    output logic                    lpx_override_en_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Slot wiring

    localparam logic [NUM_TIMINGS-1:0] OVR_RST_VEC = {
        LPX_OVR_RST,
        OVR_RESET,
        OVR_RESET,
        OVR_RESET,
        DATA_PREPARE_OVR_RST,
        OVR_RESET,
        OVR_RESET,
        OVR_RESET,
        CLK_PREPARE_OVR_RST
    };

    logic [VALUE_W-1:0]     auto_value [NUM_TIMINGS];
    logic [VALUE_W-1:0]     eff_value  [NUM_TIMINGS];
    logic [REG_W-1:0]       readback   [NUM_TIMINGS];
    logic [NUM_TIMINGS-1:0] override_vec;
    logic [NUM_TIMINGS-1:0] slot_hit;
    logic                   summary_hit;
    logic                   mapped;
    logic [NUM_TIMINGS-1:0] slot_wr;
    logic                   write_go;
    logic [DATA_W-1:0]      read_word;

    assign auto_value[0] = clk_prepare_auto_i;
    assign auto_value[1] = clk_zero_auto_i;
    assign auto_value[2] = clk_trail_auto_i;
    assign auto_value[3] = clk_post_auto_i;
    assign auto_value[4] = data_prepare_auto_i;
    assign auto_value[5] = data_zero_auto_i;
    assign auto_value[6] = data_trail_auto_i;
    assign auto_value[7] = data_exit_auto_i;
    assign auto_value[8] = lpx_auto_i;

    ////////////////////////////////////////////////////////////////////////////
    // Address decode

    timing_addr_decode u_decode (
        .paddr_i       (paddr_i),
        .slot_hit_o    (slot_hit),
        .summary_hit_o (summary_hit),
        .mapped_o      (mapped)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Bus slave state

    typedef struct packed {
        apb_state_t        fsm;
        logic              ready;
        logic              err;
        logic [DATA_W-1:0] rdata;
    } apb_regs_t;

    apb_regs_t bus_reg;
    apb_regs_t bus_next;

    // Write lands at the edge where pready is sampled high
    assign write_go = psel_i && penable_i && pwrite_i && (bus_reg.fsm == APB_DONE) && !bus_reg.err;

    always_comb begin
        for (int i = 0; i < NUM_TIMINGS; i++) begin
            // Only byte lane 0 carries register bits
            slot_wr[i] = write_go && slot_hit[i] && pstrb_i[0];
        end
    end

    always_comb begin
        read_word = '0;
        if (summary_hit) begin
            read_word[NUM_TIMINGS-1:0] = override_vec;
        end
        for (int i = 0; i < NUM_TIMINGS; i++) begin
            if (slot_hit[i]) begin
                read_word[REG_W-1:0] = readback[i];
            end
        end
    end

    always_comb begin
        bus_next = bus_reg;
        case (bus_reg.fsm)
            APB_IDLE: begin
                bus_next.ready = 1'b0;
                // Read data captured one cycle early keeps prdata on a flop
                if (psel_i && penable_i) begin
                    bus_next.fsm   = APB_DONE;
                    bus_next.ready = 1'b1;
                    bus_next.err   = !mapped || (pwrite_i && summary_hit);
                    bus_next.rdata = (pwrite_i || !mapped) ? '0 : read_word;
                end
            end
            APB_DONE: begin
                bus_next.fsm   = APB_IDLE;
                bus_next.ready = 1'b0;
                bus_next.err   = 1'b0;
                bus_next.rdata = '0;
            end
            default: begin
                bus_next.fsm   = APB_IDLE;
                bus_next.ready = 1'b0;
                bus_next.err   = 1'b0;
                bus_next.rdata = '0;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bus_reg.fsm   <= APB_IDLE;
            bus_reg.ready <= 1'b0;
            bus_reg.err   <= 1'b0;
            bus_reg.rdata <= '0;
        end else begin
            bus_reg <= bus_next;
        end
    end

    assign pready_o  = bus_reg.ready;
    assign pslverr_o = bus_reg.err;
    assign prdata_o  = bus_reg.rdata;

    ////////////////////////////////////////////////////////////////////////////
    // Timing registers, one per slot

    for (genvar g = 0; g < NUM_TIMINGS; g++) begin : g_slot
        timing_field #(
            .OVR_RST (OVR_RST_VEC[g])
        ) u_field (
            .clk_i        (clk_i),
            .rst_i        (rst_i),
            .auto_value_i (auto_value[g]),
            .wr_i         (slot_wr[g]),
            .wdata_i      (pwdata_i[REG_W-1:0]),
            .override_o   (override_vec[g]),
            .value_o      (eff_value[g]),
            .readback_o   (readback[g])
        );
    end

    ////////////////////////////////////////////////////////////////////////////
    // Effective values and flags, each straight from a field flop

    assign clk_prepare_value_o  = eff_value[0];
    assign clk_zero_value_o     = eff_value[1];
    assign clk_trail_value_o    = eff_value[2];
    assign clk_post_value_o     = eff_value[3];
    assign data_prepare_value_o = eff_value[4];
    assign data_zero_value_o    = eff_value[5];
    assign data_trail_value_o   = eff_value[6];
    assign data_exit_value_o    = eff_value[7];
    assign lpx_value_o          = eff_value[8];

    assign clk_prepare_override_en_o  = override_vec[0];
    assign clk_zero_override_en_o     = override_vec[1];
    assign clk_trail_override_en_o    = override_vec[2];
    assign clk_post_override_en_o     = override_vec[3];
    assign data_prepare_override_en_o = override_vec[4];
    assign data_zero_override_en_o    = override_vec[5];
    assign data_trail_override_en_o   = override_vec[6];
    assign data_exit_override_en_o    = override_vec[7];
    assign lpx_override_en_o          = override_vec[8];

endmodule

// ===== tb/csi_timing_monitor.sv
// Purpose: Port-level checks on the timing override bank
// Assumes: One wait state per APB transfer, sync active-high reset
// Notes:   Sees the bank's ports only
`timescale 1ns/1ps
module csi_timing_monitor
    import dphy_timing_pkg::*;
(
    // Clock, reset and APB
    input wire logic               clk_i,
    input wire logic               rst_i,
    input wire logic               psel_i,
    input wire logic               penable_i,
    input wire logic               pwrite_i,
    input wire logic [ADDR_W-1:0]  paddr_i,
    input wire logic [DATA_W-1:0]  pwdata_i,
    input wire logic [3:0]         pstrb_i,
    input wire logic               pready_o,
    input wire logic [DATA_W-1:0]  prdata_o,
    input wire logic               pslverr_o,
    // Timing ports
    input wire logic [VALUE_W-1:0] clk_zero_auto_i,
    input wire logic [VALUE_W-1:0] clk_prepare_value_o,
    input wire logic [VALUE_W-1:0] clk_zero_value_o,
    input wire logic               clk_prepare_override_en_o,
    input wire logic               clk_zero_override_en_o,
    input wire logic               clk_trail_override_en_o,
    input wire logic               clk_post_override_en_o,
    input wire logic               data_zero_override_en_o,
    input wire logic               data_trail_override_en_o,
    input wire logic               data_exit_override_en_o,
    input wire logic               lpx_override_en_o
);
    localparam logic [ADDR_W-1:0] ADDR_PREP = {2'h0, IDX_CLK_PREPARE, ALIGN_ZERO};

    default clocking @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    ////////////////////////////////////////////////////////////////////////////
    pready_pulse_a: assert property (pready_o |=> !pready_o)
        else $error("pready stayed high");
    wait_state_a: assert property ($rose(psel_i && penable_i) |-> !pready_o ##1 pready_o)
        else $error("answer not after one wait state");
    unaligned_err_a: assert property (
        $rose(psel_i && penable_i) && paddr_i[1:0] != ALIGN_ZERO |=> pready_o && pslverr_o && prdata_o == '0)
        else $error("misaligned access not refused");
    idle_rdata_a: assert property (!pready_o |-> prdata_o == '0 && !pslverr_o)
        else $error("read data or error outside answer");
    prep_override_a: assert property (
        $rose(psel_i && penable_i) && pwrite_i && pstrb_i[0] && pwdata_i[OVR_BIT] && paddr_i == ADDR_PREP
        |-> ##2 clk_prepare_override_en_o ##1 clk_prepare_value_o == $past(pwdata_i[VAL_MSB:0], 3))
        else $error("prepare override value not applied");
    zero_auto_a: assert property (
        !$past(rst_i) && !$past(clk_zero_override_en_o) && !clk_zero_override_en_o
        |-> clk_zero_value_o == $past(clk_zero_auto_i))
        else $error("zero time not following automatic value");
    reset_clear_a: assert property ($past(rst_i) |-> !(clk_zero_override_en_o || clk_trail_override_en_o
        || clk_post_override_en_o || data_zero_override_en_o || data_trail_override_en_o
        || data_exit_override_en_o) && !pready_o)
        else $error("override set after reset");
    lpx_change_a: assert property ($changed(lpx_override_en_o) |-> $past(psel_i && penable_i && pwrite_i && pready_o))
        else $error("lpx override changed without write");
endmodule

bind csi_port0_dphy_timing_override csi_timing_monitor csi_timing_monitor_i (
    .clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .pready_o(pready_o),
    .prdata_o(prdata_o), .pslverr_o(pslverr_o), .clk_zero_auto_i(clk_zero_auto_i),
    .clk_prepare_value_o(clk_prepare_value_o), .clk_zero_value_o(clk_zero_value_o),
    .clk_prepare_override_en_o(clk_prepare_override_en_o), .clk_zero_override_en_o(clk_zero_override_en_o),
    .clk_trail_override_en_o(clk_trail_override_en_o), .clk_post_override_en_o(clk_post_override_en_o),
    .data_zero_override_en_o(data_zero_override_en_o), .data_trail_override_en_o(data_trail_override_en_o),
    .data_exit_override_en_o(data_exit_override_en_o), .lpx_override_en_o(lpx_override_en_o)
);

// ===== tb/timing_source_model.sv
// Purpose: Stand-in for the lane timing engine feeding automatic values
// Assumes: Same clock as the bank
// Notes:   Values move only on request, so expected reads stay known
`timescale 1ns/1ps
module timing_source_model
    import dphy_timing_pkg::*;
(
    // Clock and control
    input  wire logic                           clk_i,
    input  wire logic                           refresh_i,
    input  wire logic [VALUE_W-1:0]             base_i,
    // Automatic values in slot order
    output logic      [NUM_TIMINGS-1:0][VALUE_W-1:0] auto_o
);
    always_ff @(posedge clk_i) begin
        if (refresh_i) begin
            for (int k = 0; k < NUM_TIMINGS; k++) begin
                auto_o[k] <= base_i + VALUE_W'(k * 11);
            end
        end
    end
endmodule

// ===== tb/csi_port0_dphy_timing_override_bench.sv
// Purpose: Self-checking bench for the timing override bank
// Assumes: One APB master, expected answers queued in issue order
// Notes:   Random automatic values and override values from a fixed seed
`timescale 1ns/1ps
module csi_port0_dphy_timing_override_bench;
    import dphy_timing_pkg::*;
    logic                                clk = 1'b0;
    logic                                rst = 1'b1;
    logic                                psel = 1'b0;
    logic                                penable = 1'b0;
    logic                                pwrite = 1'b0;
    logic                                refresh = 1'b0;
    logic [ADDR_W-1:0]                   paddr = '0;
    logic [DATA_W-1:0]                   pwdata = '0;
    logic [3:0]                          pstrb = 4'hF;
    logic [VALUE_W-1:0]                  base = 7'h00;
    logic                                pready;
    logic                                pslverr;
    logic [DATA_W-1:0]                   prdata;
    wire  [NUM_TIMINGS-1:0][VALUE_W-1:0] auto_w;
    wire  [NUM_TIMINGS-1:0][VALUE_W-1:0] eff_w;
    wire  [NUM_TIMINGS-1:0]              ovr_w;
    logic [REG_W-1:0]                    mdl [NUM_TIMINGS];
    logic [DATA_W:0]                     exp_q [$];
    int                                  fail_count = 0;
    int                                  tests_run = 0;

    always #12.5 clk = ~clk;

    timing_source_model timing_source_model_i (.clk_i(clk), .refresh_i(refresh), .base_i(base), .auto_o(auto_w));

    csi_port0_dphy_timing_override csi_port0_dphy_timing_override_i (
        .clk_i(clk), .rst_i(rst), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .pstrb_i(pstrb), .pready_o(pready), .prdata_o(prdata), .pslverr_o(pslverr),
        .clk_prepare_auto_i(auto_w[0]), .clk_zero_auto_i(auto_w[1]), .clk_trail_auto_i(auto_w[2]),
        .clk_post_auto_i(auto_w[3]), .data_prepare_auto_i(auto_w[4]), .data_zero_auto_i(auto_w[5]),
        .data_trail_auto_i(auto_w[6]), .data_exit_auto_i(auto_w[7]), .lpx_auto_i(auto_w[8]),
        .clk_prepare_value_o(eff_w[0]), .clk_zero_value_o(eff_w[1]), .clk_trail_value_o(eff_w[2]),
        .clk_post_value_o(eff_w[3]), .data_prepare_value_o(eff_w[4]), .data_zero_value_o(eff_w[5]),
        .data_trail_value_o(eff_w[6]), .data_exit_value_o(eff_w[7]), .lpx_value_o(eff_w[8]),
        .clk_prepare_override_en_o(ovr_w[0]), .clk_zero_override_en_o(ovr_w[1]),
        .clk_trail_override_en_o(ovr_w[2]), .clk_post_override_en_o(ovr_w[3]),
        .data_prepare_override_en_o(ovr_w[4]), .data_zero_override_en_o(ovr_w[5]),
        .data_trail_override_en_o(ovr_w[6]), .data_exit_override_en_o(ovr_w[7]), .lpx_override_en_o(ovr_w[8])
    );

    ////////////////////////////////////////////////////////////////////////////
    task automatic compare(input logic [DATA_W:0] got, input logic [DATA_W:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Answer watcher: each pready takes the oldest queued note
    always @(posedge clk) begin
        if (pready === 1'b1) begin
            compare({pslverr, prdata}, exp_q.size() > 0 ? exp_q.pop_front() : 'x);
        end
    end

    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                       input logic [3:0] s, input logic [DATA_W:0] exp);
        int n;
        exp_q.push_back(exp);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clk);
        penable <= 1'b1;
        for (n = 0; n < 20 && pready !== 1'b1; n++) begin
            @(posedge clk);
        end
        if (pready !== 1'b1) begin
            fail_count++;
            $display("MISMATCH at %0t: ready got %h expected %h", $time, pready, 1'b1);
            wrap_up();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    function automatic logic [ADDR_W-1:0] addr_of(input int k);
        return {2'h0, IDX_FIRST + 8'(k), ALIGN_ZERO};
    endfunction

    // Value bits load only together with a set override bit
    task automatic reg_write(input int k, input logic [REG_W-1:0] d);
        apb(1'b1, addr_of(k), DATA_W'(d), 4'hF, '0);
        if (d[OVR_BIT]) mdl[k] = d;
        else mdl[k][OVR_BIT] = 1'b0;
    endtask

    task automatic reg_read(input int k);
        apb(1'b0, addr_of(k), '0, 4'hF, {25'h0, mdl[k][OVR_BIT] ? mdl[k] : {1'b0, auto_w[k]}});
    endtask

    task automatic check_outputs();
        repeat (2) @(posedge clk);
        #1;
        for (int k = 0; k < NUM_TIMINGS; k++) begin
            compare({ovr_w[k], eff_w[k]}, mdl[k][OVR_BIT] ? mdl[k] : {1'b0, auto_w[k]});
        end
    endtask

    task automatic refresh_auto();
        @(posedge clk);
        refresh <= 1'b1;
        base <= 7'($urandom);
        @(posedge clk);
        refresh <= 1'b0;
        repeat (3) @(posedge clk);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(32'h0954D77B));
        foreach (mdl[k]) mdl[k] = 8'h00;
        refresh_auto();
        // Source warm-up already spent five of the twenty reset cycles
        repeat (15) @(posedge clk);
        rst <= 1'b0;
        check_outputs();
        for (int k = 0; k < NUM_TIMINGS; k++) reg_read(k);
        $display("Test reset values done");
        for (int k = 0; k < NUM_TIMINGS; k++) begin
            reg_write(k, {1'b1, 7'($urandom)});
            reg_read(k);
        end
        reg_write(8, 8'hFF);
        refresh_auto();
        check_outputs();
        $display("Test override set done");
        for (int k = 0; k < NUM_TIMINGS; k++) reg_write(k, {1'b0, ~mdl[k][VAL_MSB:0]});
        refresh_auto();
        for (int k = 0; k < NUM_TIMINGS; k++) reg_read(k);
        check_outputs();
        $display("Test override clear done");
        apb(1'b0, addr_of(0) | 12'h001, '0, 4'hF, {1'b1, 32'h0});
        apb(1'b1, {2'h0, IDX_SUMMARY, ALIGN_ZERO}, 32'h1FF, 4'hF, {1'b1, 32'h0});
        apb(1'b0, 12'hFFC, '0, 4'hF, {1'b1, 32'h0});
        apb(1'b1, addr_of(3), 32'h0000_00AB, 4'h0, '0);
        reg_read(3);
        $display("Test refused access done");
        reg_write(1, 8'hC5);
        reg_write(7, 8'h80);
        reg_write(5, 8'h80);
        reg_write(6, 8'h80);
        // Summary: override flags of slots 1, 5, 6 and 7
        apb(1'b0, {2'h0, IDX_SUMMARY, ALIGN_ZERO}, '0, 4'hF, {1'b0, 32'h0000_00E2});
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        foreach (mdl[k]) mdl[k] = 8'h00;
        check_outputs();
        $display("Test second reset done");
        wrap_up();
    end
endmodule
